// *** rtl/burner_pkg.sv ***
// Shared constants and types for the burner sequence controller.
// Assumes a 100 MHz system clock and one synchronous active-high reset.
package burner_pkg;

  // Clock and the divided timing tick
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TW            = 16;

  // Sequence times in milliseconds
  localparam int unsigned AIR_MAX_MS     = 60000;
  localparam int unsigned PREPURGE_MS    = 44000;
  localparam int unsigned DAMPER_OPEN_MS = 36000;
  localparam int unsigned DAMPER_CLOSE_MS = 8000;
  localparam int unsigned PREIGN_MS      = 3000;
  localparam int unsigned IGN_TOTAL_MS   = 5500;
  localparam int unsigned STRAY_MS       = 5000;
  localparam int unsigned SAFETY_MS      = 3000;
  localparam int unsigned DELAY2_MS      = 6000;
  localparam int unsigned FAN_BRIEF_MS   = 2500;
  localparam int unsigned QUICK_LOCK_MS  = 10000;
  localparam int unsigned BTN_LONG_MS    = 3000;
  localparam int unsigned DEB_MS         = 50;

  // Indicator times in milliseconds
  localparam int unsigned LOCK_ON_MS   = 10000;
  localparam int unsigned LOCK_GAP1_MS = 600;
  localparam int unsigned LOCK_END_MS  = 1200;
  localparam int unsigned PULSE_S_MS   = 200;
  localparam int unsigned PULSE_L_MS   = 600;
  localparam int unsigned GAP_P_MS     = 200;
  localparam int unsigned END_S_MS     = 800;
  localparam int unsigned GAP_L_MS     = 2000;

  // The same times as tick counts
  localparam logic [TW-1:0] AIR_MAX_T   = TW'(AIR_MAX_MS / TICK_MS);
  localparam logic [TW-1:0] PREPURGE_T  = TW'(PREPURGE_MS / TICK_MS);
  localparam logic [TW-1:0] CLOSE_T     = TW'((PREPURGE_MS - DAMPER_OPEN_MS) / TICK_MS);
  localparam logic [TW-1:0] PREIGN_T    = TW'(PREIGN_MS / TICK_MS);
  localparam logic [TW-1:0] STRAY_T     = TW'(STRAY_MS / TICK_MS);
  localparam logic [TW-1:0] SAFETY_T    = TW'(SAFETY_MS / TICK_MS);
  localparam logic [TW-1:0] IGN_OFF_T   = TW'((SAFETY_MS - (IGN_TOTAL_MS - PREIGN_MS)) / TICK_MS);
  localparam logic [TW-1:0] DELAY2_T    = TW'(DELAY2_MS / TICK_MS);
  localparam logic [TW-1:0] FAN_BRIEF_T = TW'(FAN_BRIEF_MS / TICK_MS);
  localparam logic [TW-1:0] QUICK_T     = TW'(QUICK_LOCK_MS / TICK_MS);
  localparam logic [TW-1:0] BTN_LONG_T  = TW'(BTN_LONG_MS / TICK_MS + 1);
  localparam logic [2:0]    DEB_T       = 3'(DEB_MS / TICK_MS);
  localparam logic [TW-1:0] LOCK_ON_T   = TW'(LOCK_ON_MS / TICK_MS);
  localparam logic [TW-1:0] LOCK_GAP1_T = TW'(LOCK_GAP1_MS / TICK_MS);
  localparam logic [TW-1:0] LOCK_END_T  = TW'(LOCK_END_MS / TICK_MS);
  localparam logic [TW-1:0] PULSE_S_T   = TW'(PULSE_S_MS / TICK_MS);
  localparam logic [TW-1:0] PULSE_L_T   = TW'(PULSE_L_MS / TICK_MS);
  localparam logic [TW-1:0] GAP_P_T     = TW'(GAP_P_MS / TICK_MS);
  localparam logic [TW-1:0] END_S_T     = TW'(END_S_MS / TICK_MS);
  localparam logic [TW-1:0] GAP_L_T     = TW'(GAP_L_MS / TICK_MS);

  // Field input positions
  localparam int unsigned NIN       = 6;
  localparam int unsigned IN_AIR    = 0;
  localparam int unsigned IN_FLAME  = 1;
  localparam int unsigned IN_MLOW   = 2;
  localparam int unsigned IN_MOK    = 3;
  localparam int unsigned IN_BTN    = 4;
  localparam int unsigned IN_DEMAND = 5;

  // Lockout cause, also the stored code
  typedef enum logic [2:0] {
    CAUSE_NONE        = 3'h0,
    CAUSE_SAFETY      = 3'h1,
    CAUSE_STRAY       = 3'h2,
    CAUSE_AIR_CLOSED  = 3'h3,
    CAUSE_AIR_TIMEOUT = 3'h4,
    CAUSE_AIR_OPENED  = 3'h5,
    CAUSE_FLAME_LOSS  = 3'h6,
    CAUSE_MANUAL      = 3'h7
  } cause_t;

  typedef enum logic [3:0] {
    S_BOOT, S_IDLE, S_PRECHK, S_QUICK, S_WAIT_AIR, S_PREPURGE,
    S_PREIGN, S_SAFETY, S_DELAY2, S_RUN, S_LOCK, S_UNDERV
  } phase_t;

  typedef enum logic [2:0] {L_ON, L_GAP1, L_PULSE, L_GAP, L_END} led_t;

  // Flash pattern: first group, second group, pause kind
  typedef struct packed {
    logic [2:0] n1;
    logic       first_long;
    logic [2:0] n2;
    logic       long_end;
  } pat_t;

  localparam pat_t PAT_WAIT     = {3'h2, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_PREPURGE = {3'h3, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_PREIGN   = {3'h4, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_SAFETY   = {3'h2, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_DELAY2   = {3'h3, 1'b1, 3'h0, 1'b0};
  localparam pat_t PAT_RUN      = {3'h1, 1'b0, 3'h0, 1'b1};
  localparam pat_t PAT_UNDERV   = {3'h1, 1'b1, 3'h0, 1'b1};
  localparam pat_t PAT_C_SAFETY = {3'h4, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_C_STRAY  = {3'h3, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_C_ACLOSE = {3'h2, 1'b1, 3'h0, 1'b0};
  localparam pat_t PAT_C_ATOUT  = {3'h3, 1'b1, 3'h0, 1'b0};
  localparam pat_t PAT_C_AOPEN  = {3'h2, 1'b0, 3'h0, 1'b0};
  localparam pat_t PAT_C_LOSS   = {3'h4, 1'b1, 3'h0, 1'b0};
  localparam pat_t PAT_C_MANUAL = {3'h5, 1'b0, 3'h4, 1'b0};
  localparam pat_t PAT_C_NONE   = {3'h1, 1'b0, 3'h0, 1'b0};

  // One debounced input channel
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [2:0] cnt;
    logic       out;
  } deb_t;

  // Whole controller state
  typedef struct packed {
    phase_t          ph;
    cause_t          cause;
    logic [TW-1:0]   ptmr;
    logic            retried;
    logic [TW-1:0]   btmr;
    logic            btn;
    led_t            ls;
    pat_t            pat;
    logic [3:0]      idx;
    logic [TW-1:0]   ltmr;
    logic            lk;
    logic [31:0]     div;
    logic            tick;
    logic            fan;
    logic            damper;
    logic            ign;
    logic            v1;
    logic            v2;
    logic            alarm;
    logic            led;
    logic            nv_wr;
  } ctl_t;

  localparam ctl_t CTL_RST = '0;

endpackage : burner_pkg

// *** rtl/input_debounce.sv ***
// Synchronises and debounces the field inputs on the timing tick.
// Assumes tick_i is a one-cycle pulse from the controller's divider.
`timescale 1ns/100ps
`default_nettype none
module input_debounce #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] raw_i,
  output logic      [W-1:0] clean_o
);
  import burner_pkg::*;

  deb_t [W-1:0] q;
  deb_t [W-1:0] d;

  // Two-flop sync, then a level must hold for DEB_T ticks
  always_comb begin
    d = q;
    for (int i = 0; i < W; i++) begin
      d[i].s1 = raw_i[i];
      d[i].s2 = q[i].s1;
      if (q[i].s2 == q[i].out) begin
        d[i].cnt = '0;
      end else if (tick_i) begin
        if (q[i].cnt == DEB_T - 3'h1) begin
          d[i].out = q[i].s2;
          d[i].cnt = '0;
        end else begin
          d[i].cnt = q[i].cnt + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Clean levels
  always_comb begin
    for (int i = 0; i < W; i++) begin
      clean_o[i] = q[i].out;
    end
  end

endmodule : input_debounce
`default_nettype wire

// *** rtl/burner_sequencer.sv ***
// Two-stage gas burner sequence controller with flash-code indicator.
// Assumes asynchronous field inputs and an external non-volatile cause store.
`timescale 1ns/100ps
`default_nettype none
module burner_sequencer #(
  parameter int unsigned TICK_DIV = burner_pkg::TICK_CYCLES
) (
  input  wire logic                  CLK_I,
  input  wire logic                  SRST_I,
  input  wire logic                  DEMAND_I,
  input  wire logic                  AIR_SWITCH_I,
  input  wire logic                  FLAME_I,
  input  wire logic                  MAINS_LOW_I,
  input  wire logic                  MAINS_OK_I,
  input  wire logic                  RESET_BTN_I,
  input  wire burner_pkg::cause_t    NV_CAUSE_I,
  output logic                       FAN_O,
  output logic                       DAMPER_O,
  output logic                       IGNITION_O,
  output logic                       VALVE1_O,
  output logic                       VALVE2_O,
  output logic                       ALARM_O,
  output logic                       LED_O,
  output logic                       NV_WR_O,
  output burner_pkg::cause_t         NV_CAUSE_O
);
  import burner_pkg::*;

  ctl_t           q;
  ctl_t           d;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] cln;
  logic           air;
  logic           flame;
  logic           press_s;
  logic           press_l;
  logic           lock_req;
  cause_t         lock_cause;
  logic           lock_disp;
  pat_t           npat;
  logic           active;

  // Pattern of a running phase
  function automatic pat_t phase_pat(input phase_t p);
    case (p)
      S_PREPURGE: phase_pat = PAT_PREPURGE;
      S_PREIGN:   phase_pat = PAT_PREIGN;
      S_SAFETY:   phase_pat = PAT_SAFETY;
      S_DELAY2:   phase_pat = PAT_DELAY2;
      S_RUN:      phase_pat = PAT_RUN;
      S_UNDERV:   phase_pat = PAT_UNDERV;
      default:    phase_pat = PAT_WAIT;
    endcase
  endfunction : phase_pat

  // Pattern of a lockout cause
  function automatic pat_t cause_pat(input cause_t c);
    case (c)
      CAUSE_SAFETY:      cause_pat = PAT_C_SAFETY;
      CAUSE_STRAY:       cause_pat = PAT_C_STRAY;
      CAUSE_AIR_CLOSED:  cause_pat = PAT_C_ACLOSE;
      CAUSE_AIR_TIMEOUT: cause_pat = PAT_C_ATOUT;
      CAUSE_AIR_OPENED:  cause_pat = PAT_C_AOPEN;
      CAUSE_FLAME_LOSS:  cause_pat = PAT_C_LOSS;
      CAUSE_MANUAL:      cause_pat = PAT_C_MANUAL;
      default:           cause_pat = PAT_C_NONE;
    endcase
  endfunction : cause_pat

  // Field inputs gathered for the debouncer
  always_comb begin
    raw            = '0;
    raw[IN_AIR]    = AIR_SWITCH_I;
    raw[IN_FLAME]  = FLAME_I;
    raw[IN_MLOW]   = MAINS_LOW_I;
    raw[IN_MOK]    = MAINS_OK_I;
    raw[IN_BTN]    = RESET_BTN_I;
    raw[IN_DEMAND] = DEMAND_I;
  end

  input_debounce #(.W(NIN)) input_debounce_inst (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .tick_i  (q.tick),
    .raw_i   (raw),
    .clean_o (cln)
  );

  assign air   = cln[IN_AIR];
  assign flame = cln[IN_FLAME];

  // Sequence, button, indicator and outputs
  always_comb begin
    d          = q;
    d.nv_wr    = 1'b0;
    press_s    = 1'b0;
    press_l    = 1'b0;
    lock_req   = 1'b0;
    lock_cause = CAUSE_NONE;
    // Single divided tick drives every timer
    d.tick = (q.div == 32'(TICK_DIV - 1));
    d.div  = d.tick ? 32'h0 : q.div + 32'h1;
    if (q.tick && q.ptmr != '0) d.ptmr = q.ptmr - 16'h1;
    if (q.tick && q.ltmr != '0) d.ltmr = q.ltmr - 16'h1;
    // Button hold timer, judged on release
    d.btn = cln[IN_BTN];
    if (cln[IN_BTN]) begin
      if (q.tick && q.btmr != BTN_LONG_T) d.btmr = q.btmr + 16'h1;
    end else begin
      d.btmr = '0;
      if (q.btn) begin
        press_l = (q.btmr == BTN_LONG_T);
        press_s = !press_l;
      end
    end
    active = q.ph inside {S_PRECHK, S_WAIT_AIR, S_PREPURGE, S_PREIGN,
                          S_SAFETY, S_DELAY2, S_RUN};
    case (q.ph)
      S_BOOT: begin
        // Stored cause brings the lockout back after power-up
        if (NV_CAUSE_I != CAUSE_NONE) begin
          d.ph    = S_LOCK;
          d.cause = NV_CAUSE_I;
        end else begin
          d.ph = S_IDLE;
        end
      end
      S_IDLE: begin
        // Start only with mains good and not low
        if (cln[IN_DEMAND] && cln[IN_MOK] && !cln[IN_MLOW]) begin
          if (air) begin
            if (q.retried) begin
              lock_req   = 1'b1;
              lock_cause = CAUSE_AIR_CLOSED;
            end else begin
              d.ph   = S_PRECHK;
              d.ptmr = FAN_BRIEF_T;
            end
          end else begin
            d.ph      = S_WAIT_AIR;
            d.ptmr    = AIR_MAX_T;
            d.retried = 1'b0;
          end
        end
      end
      S_PRECHK: begin
        if (q.ptmr == '0) begin
          d.ph      = S_QUICK;
          d.ptmr    = QUICK_T;
          d.retried = 1'b1;
          d.cause   = CAUSE_AIR_CLOSED;
        end
      end
      S_QUICK: begin
        if (q.ptmr == '0) begin
          d.ph    = S_IDLE;
          d.cause = CAUSE_NONE;
        end
      end
      S_WAIT_AIR: begin
        if (air) begin
          d.ph   = S_PREPURGE;
          d.ptmr = PREPURGE_T;
        end else if (q.ptmr == '0) begin
          lock_req   = 1'b1;
          lock_cause = CAUSE_AIR_TIMEOUT;
        end
      end
      S_PREPURGE: begin
        if (q.ptmr <= STRAY_T && flame) begin
          lock_req   = 1'b1;
          lock_cause = CAUSE_STRAY;
        end else if (q.ptmr == '0) begin
          d.ph   = S_PREIGN;
          d.ptmr = PREIGN_T;
        end
      end
      S_PREIGN: begin
        if (q.ptmr == '0) begin
          d.ph   = S_SAFETY;
          d.ptmr = SAFETY_T;
        end
      end
      S_SAFETY: begin
        if (q.ptmr == '0) begin
          if (flame) begin
            d.ph   = S_DELAY2;
            d.ptmr = DELAY2_T;
          end else begin
            lock_req   = 1'b1;
            lock_cause = CAUSE_SAFETY;
          end
        end
      end
      S_DELAY2, S_RUN: begin
        if (!flame) begin
          lock_req   = 1'b1;
          lock_cause = CAUSE_FLAME_LOSS;
        end else if (q.ph == S_DELAY2 && q.ptmr == '0) begin
          d.ph = S_RUN;
        end
      end
      S_LOCK: begin
        if (press_s) begin
          d.ph      = S_IDLE;
          d.cause   = CAUSE_NONE;
          d.retried = 1'b0;
          d.nv_wr   = 1'b1;
        end
      end
      S_UNDERV: begin
        if (cln[IN_MOK] && !cln[IN_MLOW]) d.ph = S_IDLE;
      end
      default: d.ph = S_BOOT;
    endcase
    // Faults common to the active phases; air loss is not checked in S_PRECHK or S_WAIT_AIR
    if (active) begin
      if (!cln[IN_DEMAND]) d.ph = S_IDLE;
      if (cln[IN_MLOW]) begin
        d.ph     = S_UNDERV;
        lock_req = 1'b0;
      end else if (press_l) begin
        lock_req   = 1'b1;
        lock_cause = CAUSE_MANUAL;
      end else if (!air && q.ph != S_PRECHK && q.ph != S_WAIT_AIR) begin
        lock_req   = 1'b1;
        lock_cause = CAUSE_AIR_OPENED;
      end
    end
    if (lock_req) begin
      d.ph    = S_LOCK;
      d.cause = lock_cause;
      d.nv_wr = 1'b1;
    end
    // Relay outputs from the next phase
    d.fan    = d.ph inside {S_PRECHK, S_WAIT_AIR, S_PREPURGE, S_PREIGN,
                            S_SAFETY, S_DELAY2, S_RUN};
    d.damper = (d.ph == S_PREPURGE) && (d.ptmr > CLOSE_T);
    d.ign    = (d.ph == S_PREIGN) ||
               ((d.ph == S_SAFETY) && (d.ptmr > IGN_OFF_T));
    d.v1     = d.ph inside {S_SAFETY, S_DELAY2, S_RUN};
    d.v2     = (d.ph == S_RUN);
    d.alarm  = (d.ph == S_LOCK);
    // Flash-code engine
    lock_disp = d.ph inside {S_LOCK, S_QUICK};
    npat      = lock_disp ? cause_pat(d.cause) : phase_pat(d.ph);
    if (lock_disp != q.lk) begin
      d.lk   = lock_disp;
      d.pat  = npat;
      d.idx  = '0;
      d.ls   = lock_disp ? L_ON : L_PULSE;
      d.ltmr = lock_disp ? LOCK_ON_T : PULSE_S_T;
    end else if (q.ltmr == '0) begin
      case (q.ls)
        L_ON: begin
          d.ls   = L_GAP1;
          d.ltmr = LOCK_GAP1_T;
        end
        L_GAP: begin
          d.ls   = L_PULSE;
          d.ltmr = PULSE_S_T;
        end
        L_PULSE: begin
          d.idx = q.idx + 4'h1;
          if (d.idx == {1'b0, q.pat.n1} + {1'b0, q.pat.n2}) begin
            d.ls   = L_END;
            d.ltmr = q.lk ? LOCK_END_T :
                     (q.pat.long_end ? GAP_L_T : END_S_T);
          end else begin
            d.ls   = L_GAP;
            d.ltmr = (d.idx == {1'b0, q.pat.n1}) ? GAP_L_T : GAP_P_T;
          end
        end
        L_END: begin
          if (q.lk) begin
            d.ls   = L_ON;
            d.ltmr = LOCK_ON_T;
          end else begin
            d.pat  = npat;
            d.idx  = '0;
            d.ls   = L_PULSE;
            d.ltmr = npat.first_long ? PULSE_L_T : PULSE_S_T;
          end
        end
        default: begin
          // Burst start after the lockout pause
          d.pat  = npat;
          d.idx  = '0;
          d.ls   = L_PULSE;
          d.ltmr = npat.first_long ? PULSE_L_T : PULSE_S_T;
        end
      endcase
    end
    d.led = (d.ls inside {L_ON, L_PULSE}) && !(d.ph inside {S_BOOT, S_IDLE});
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  // Registered outputs
  assign FAN_O      = q.fan;
  assign DAMPER_O   = q.damper;
  assign IGNITION_O = q.ign;
  assign VALVE1_O   = q.v1;
  assign VALVE2_O   = q.v2;
  assign ALARM_O    = q.alarm;
  assign LED_O      = q.led;
  assign NV_WR_O    = q.nv_wr;
  assign NV_CAUSE_O = q.cause;

endmodule : burner_sequencer
`default_nettype wire

// *** tb/burner_sequencer_monitor.sv ***
// Assertion checker for the burner sequence controller ports.
// Assumes it is bound into burner_sequencer and shares its TICK_DIV.
`timescale 1ns/100ps
`default_nettype none
module burner_sequencer_monitor #(
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic               CLK_I,
  input wire logic               SRST_I,
  input wire logic               MAINS_LOW_I,
  input wire logic               RESET_BTN_I,
  input wire logic               FAN_O,
  input wire logic               DAMPER_O,
  input wire logic               IGNITION_O,
  input wire logic               VALVE1_O,
  input wire logic               VALVE2_O,
  input wire logic               ALARM_O,
  input wire logic               LED_O,
  input wire logic               NV_WR_O,
  input wire burner_pkg::cause_t NV_CAUSE_O
);
  import burner_pkg::*;
  localparam int TD = TICK_DIV;
  logic [15:0] ign_q, dmp_q, air_q, led_q, btn_q, low_q;

  // Run lengths of the watched conditions, in clock cycles
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      {ign_q, dmp_q, air_q, led_q, btn_q, low_q} <= '0;
    end else begin
      ign_q <= IGNITION_O ? ign_q + 16'h1 : '0;
      dmp_q <= DAMPER_O ? dmp_q + 16'h1 : '0;
      air_q <= (FAN_O && !DAMPER_O && !IGNITION_O && !VALVE1_O) ? air_q + 16'h1 : '0;
      led_q <= (LED_O && ALARM_O) ? led_q + 16'h1 : '0;
      btn_q <= RESET_BTN_I ? '0 : btn_q + {15'h0, ~&btn_q};
      low_q <= MAINS_LOW_I ? low_q + {15'h0, ~&low_q} : '0;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  // Burner outputs and lockout behaviour
  a_lock_relays_off: assert property (ALARM_O |->
    !(FAN_O || DAMPER_O || IGNITION_O || VALVE1_O || VALVE2_O)) else $error("relay on in lockout");
  a_nv_write_pulse: assert property (NV_WR_O |=> !NV_WR_O)
    else $error("store write longer than one cycle");
  a_nv_cause_match: assert property (NV_WR_O |-> ALARM_O == (NV_CAUSE_O != CAUSE_NONE))
    else $error("stored cause disagrees with alarm");
  a_ign_total_time: assert property ($fell(IGNITION_O) && VALVE1_O |->
    ign_q >= 548 * TD && ign_q <= 552 * TD) else $error("ignition time wrong");
  a_damper_open_time: assert property ($fell(DAMPER_O) && FAN_O |->
    dmp_q >= 3598 * TD && dmp_q <= 3602 * TD) else $error("damper open time wrong");
  a_air_wait_bound: assert property (air_q <= 6002 * TD)
    else $error("air switch wait too long");
  a_lock_led_steady: assert property ($fell(LED_O) && ALARM_O |->
    led_q <= 62 * TD || (led_q >= 998 * TD && led_q <= 1002 * TD)) else $error("lockout led span");
  a_latch_until_btn: assert property ($fell(ALARM_O) |-> btn_q <= 12 * TD)
    else $error("lockout cleared without button");
  a_undervolt_stop: assert property (low_q > 10 * TD |->
    !(FAN_O || VALVE1_O || IGNITION_O)) else $error("running on low mains");

  // Main scenarios reached
  c_run: cover property ($rose(VALVE2_O));
  c_lock: cover property ($rose(ALARM_O) && NV_WR_O);
  c_clear: cover property ($fell(ALARM_O));
endmodule : burner_sequencer_monitor
bind burner_sequencer burner_sequencer_monitor #(.TICK_DIV(TICK_DIV)) monitor_inst (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .MAINS_LOW_I(MAINS_LOW_I), .RESET_BTN_I(RESET_BTN_I),
  .FAN_O(FAN_O), .DAMPER_O(DAMPER_O), .IGNITION_O(IGNITION_O), .VALVE1_O(VALVE1_O),
  .VALVE2_O(VALVE2_O), .ALARM_O(ALARM_O), .LED_O(LED_O), .NV_WR_O(NV_WR_O),
  .NV_CAUSE_O(NV_CAUSE_O));
`default_nettype wire

// *** tb/burner_field_model.sv ***
// Behavioural field side: air pressure switch and flame detector.
// Assumes knob_i is changed by the bench away from the clock edge.
`timescale 1ns/100ps
`default_nettype none
module burner_field_model #(
  parameter int unsigned SLOW = 1800
) (
  input  wire logic       clk_i,
  input  wire logic       fan_i,
  input  wire logic       valve1_i,
  input  wire logic [5:0] knob_i,
  output logic            air_o,
  output logic            flame_o
);
  // Knobs: 0 slow air, 1 welded contact, 2 air lost, 3 no fuel, 4 stray light, 5 flame lost
  int unsigned run_q = 0;

  // Time the fan has been building pressure
  always_ff @(posedge clk_i) begin
    run_q <= fan_i ? run_q + 1 : 0;
  end

  // Contact opens when the fan stops, closes after the pressure delay
  assign air_o = knob_i[1] | (fan_i & ~knob_i[2] & (run_q > (knob_i[0] ? SLOW : 20)));
  // Flame follows the first valve unless fuel or flame fails
  assign flame_o = knob_i[4] | (valve1_i & ~knob_i[3] & ~knob_i[5]);
endmodule : burner_field_model
`default_nettype wire

// *** tb/burner_sequencer_test.sv ***
// Self-checking bench for the burner sequence controller.
// Assumes a shortened tick and the behavioural field model.
`timescale 1ns/100ps
`default_nettype none
module burner_sequencer_test;
  import burner_pkg::*;
  localparam int TD = 3;
  logic   CLK_I = 1'b0, SRST_I = 1'b1, DEMAND_I = 1'b0, RESET_BTN_I = 1'b0;
  logic   MAINS_LOW_I = 1'b0, MAINS_OK_I = 1'b1, AIR_SWITCH_I, FLAME_I;
  logic   FAN_O, DAMPER_O, IGNITION_O, VALVE1_O, VALVE2_O, ALARM_O, LED_O, NV_WR_O;
  cause_t NV_CAUSE_I = CAUSE_FLAME_LOSS;
  cause_t NV_CAUSE_O;
  logic [5:0] knob = '0;
  int     bad_count = 0;
  int     samples_checked = 0;
  int     n, g;
  wire logic [4:0] obs = {ALARM_O, VALVE2_O, IGNITION_O, DAMPER_O, FAN_O};

  always #5 CLK_I = ~CLK_I;

  burner_sequencer #(.TICK_DIV(TD)) burner_sequencer_inst (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .DEMAND_I(DEMAND_I), .AIR_SWITCH_I(AIR_SWITCH_I), .FLAME_I(FLAME_I),
    .MAINS_LOW_I(MAINS_LOW_I), .MAINS_OK_I(MAINS_OK_I), .RESET_BTN_I(RESET_BTN_I),
    .NV_CAUSE_I(NV_CAUSE_I), .FAN_O(FAN_O), .DAMPER_O(DAMPER_O), .IGNITION_O(IGNITION_O),
    .VALVE1_O(VALVE1_O), .VALVE2_O(VALVE2_O), .ALARM_O(ALARM_O), .LED_O(LED_O),
    .NV_WR_O(NV_WR_O), .NV_CAUSE_O(NV_CAUSE_O));
  burner_field_model #(.SLOW(600 * TD)) burner_field_model_inst (.clk_i(CLK_I), .fan_i(FAN_O),
    .valve1_i(VALVE1_O), .knob_i(knob), .air_o(AIR_SWITCH_I), .flame_o(FLAME_I));

  task test_done;
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Waits a bounded number of ticks for one output to reach a level
  task wait_on(input int b, input logic v, input int t);
    int c;
    c = 0;
    while (obs[b] !== v && c < t * TD) begin
      @(negedge CLK_I);
      c++;
    end
    chk(8'(obs[b]), 8'(v));
  endtask : wait_on

  task press(input int t);
    RESET_BTN_I = 1'b1;
    repeat (t * TD) @(negedge CLK_I);
    RESET_BTN_I = 1'b0;
    repeat (20 * TD) @(negedge CLK_I);
  endtask : press

  // Counts pulses in one phase group, bounded by long pauses
  task burst(output int n);
    int lo;
    logic pl;
    lo = 0;
    n = 0;
    pl = 1'b0;
    while (lo < 70 * TD) begin
      @(negedge CLK_I);
      lo = LED_O ? 0 : lo + 1;
    end
    lo = 0;
    while (lo < 70 * TD || n == 0) begin
      @(negedge CLK_I);
      if (LED_O && !pl) n++;
      pl = LED_O;
      lo = LED_O ? 0 : lo + 1;
    end
  endtask : burst

  // Lockout cycle: first pause length and pulses until the next steady light
  task lock_code(output int n, output int g);
    int hi;
    logic pl;
    n = 0;
    g = 0;
    hi = 0;
    pl = 1'b1;
    while (LED_O !== 1'b0) @(negedge CLK_I);
    while (LED_O !== 1'b1) begin
      @(negedge CLK_I);
      g++;
    end
    while (hi < 200 * TD) begin
      @(negedge CLK_I);
      if (LED_O && !pl) n++;
      pl = LED_O;
      hi = LED_O ? hi + 1 : 0;
    end
  endtask : lock_code

  task unlock;
    DEMAND_I = 1'b0;
    knob = '0;
    press(20);
    chk(8'(ALARM_O), 8'h00);
    chk(8'(NV_CAUSE_O), 8'h00);
  endtask : unlock

  task t_boot;
    chk(8'(ALARM_O), 8'h01);
    chk(8'(NV_CAUSE_O), 8'h06);
    lock_code(n, g);
    chk(8'(n), 8'h04);
    chk(8'(g >= 58 * TD && g <= 62 * TD), 8'h01);
    unlock();
  endtask : t_boot

  task t_run;
    knob = 6'h01;
    DEMAND_I = 1'b1;
    wait_on(0, 1'b1, 20);
    burst(n);
    chk(8'(n), 8'h02);
    wait_on(1, 1'b1, 700);
    burst(n);
    chk(8'(n), 8'h03);
    wait_on(3, 1'b1, 5800);
    chk(8'(VALVE1_O), 8'h01);
    burst(n);
    chk(8'(n), 8'h01);
    knob = 6'h21;
    wait_on(4, 1'b1, 20);
    chk(8'(NV_WR_O), 8'h01);
    chk(8'(NV_CAUSE_O), 8'h06);
    repeat (300 * TD) @(negedge CLK_I);
    chk(8'(ALARM_O), 8'h01);
    unlock();
  endtask : t_run

  task t_airopen;
    DEMAND_I = 1'b1;
    wait_on(1, 1'b1, 100);
    knob = 6'h04;
    wait_on(4, 1'b1, 20);
    chk(8'(NV_CAUSE_O), 8'h05);
    lock_code(n, g);
    chk(8'(n), 8'h02);
    unlock();
  endtask : t_airopen

  // Air switch never closes: time-out lockout after the maximum wait
  task t_atout;
    knob = 6'h04;
    DEMAND_I = 1'b1;
    wait_on(0, 1'b1, 20);
    repeat (5900 * TD) @(negedge CLK_I);
    chk(8'(ALARM_O), 8'h00);
    wait_on(4, 1'b1, 200);
    chk(8'(NV_CAUSE_O), 8'h04);
    unlock();
  endtask : t_atout

  task t_stray;
    DEMAND_I = 1'b1;
    wait_on(1, 1'b1, 100);
    wait_on(1, 1'b0, 3700);
    knob = 6'h10;
    wait_on(4, 1'b1, 900);
    chk(8'(NV_CAUSE_O), 8'h02);
    unlock();
  endtask : t_stray

  task t_nofuel;
    knob = 6'h08;
    DEMAND_I = 1'b1;
    wait_on(2, 1'b1, 5000);
    wait_on(4, 1'b1, 700);
    chk(8'(NV_CAUSE_O), 8'h01);
    lock_code(n, g);
    chk(8'(n), 8'h04);
    unlock();
  endtask : t_nofuel

  task t_manual;
    knob = 6'h01;
    DEMAND_I = 1'b1;
    wait_on(0, 1'b1, 20);
    press(320);
    wait_on(4, 1'b1, 20);
    chk(8'(NV_CAUSE_O), 8'h07);
    lock_code(n, g);
    chk(8'(n), 8'h09);
    unlock();
  endtask : t_manual

  task t_mains;
    knob = 6'h01;
    DEMAND_I = 1'b1;
    wait_on(0, 1'b1, 20);
    MAINS_LOW_I = 1'b1;
    MAINS_OK_I = 1'b0;
    wait_on(0, 1'b0, 20);
    repeat (300 * TD) @(negedge CLK_I);
    chk(8'(FAN_O), 8'h00);
    MAINS_LOW_I = 1'b0;
    MAINS_OK_I = 1'b1;
    wait_on(0, 1'b1, 30);
    DEMAND_I = 1'b0;
    knob = '0;
    repeat (20 * TD) @(negedge CLK_I);
  endtask : t_mains

  task t_weld;
    knob = 6'h02;
    DEMAND_I = 1'b1;
    wait_on(0, 1'b1, 20);
    repeat (600 * TD) @(negedge CLK_I);
    chk(8'(ALARM_O), 8'h00);
    wait_on(4, 1'b1, 1600);
    chk(8'(NV_CAUSE_O), 8'h03);
    unlock();
  endtask : t_weld

  // Main sequence
  initial begin
    repeat (20) @(negedge CLK_I);
    SRST_I = 1'b0;
    repeat (4) @(negedge CLK_I);
    NV_CAUSE_I = CAUSE_NONE;
    t_boot();
    t_run();
    t_airopen();
    t_atout();
    t_stray();
    t_nofuel();
    t_manual();
    t_mains();
    t_weld();
    test_done();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (33000 * TD) @(posedge CLK_I);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : burner_sequencer_test
`default_nettype wire
